// [serial_eeprom_autoload.sv]
`timescale 1ns/1ns
`default_nettype none
`include "serial_eeprom_params.svh"
// Behaviour
// - After each reset read the first 13 EEPROM words and apply them.
// - Word map: IDs, reserved, autoload, vendor, device, power, reserved, station address.
// - Subsystem vendor and subsystem ID appear at configuration offset 2CH.
// - Vendor and device words load only when autoload low nibble is 1010.
// - Otherwise built-in default vendor and device IDs are presented.
// - Capability and power bytes load only when autoload high nibble is 1X1X.
// - Autoload bit 4 picks wake pin polarity: clear high, set low.
// - Autoload bit 6 picks wake signalling: clear pulse, set level.
// - New-capability bit 0 goes to command/status bit 20.
// - If new-capability bit 1, bits 4:2 to 18:16 and 7:5 to 24:22.
// - Power capability bits 7:3 go to capability register bits 31:27.
// - Power capability bits 2:0 go to bits 21, 26 and 25.
// - Power control bit 3 set: PME output never driven.
// - Power control bit 2 set: wake pin kept inactive.
// - Power control bit 1 set: link change is a wake event.
// - Power control bit 0 set: magic packet is a wake event.
// - Station address bytes from words 10-12, low byte then high byte.
module serial_eeprom_autoload #(
    parameter logic [15:0] DEFAULT_VENDOR_ID = 16'h5A5A, // Arbitrary value
    parameter logic [15:0] DEFAULT_DEVICE_ID = 16'hA5A5, // Arbitrary value
    parameter int          SK_HALF           = `EE_SK_HALF_CYC,
    parameter int          PULSE_CYC         = `WAKE_PULSE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var logic  [31:0] prdata,
    output var logic         pready,
    output var logic         pslverr,
    output var logic         ee_cs,
    output var logic         ee_sk,
    output var logic         ee_di,
    input  wire logic        ee_do,
    input  wire logic        link_change_event,
    input  wire logic        magic_packet_event,
    output var logic         wake_pin,
    output var logic         pme_n_out,
    output var logic         pme_n_oe
);
    import serial_eeprom_pkg::*;

    eeprom_bus_if bus ();
    load_state_type state;
    logic [3:0]  word_idx;
    word_type    word_q [0:`LOAD_WORDS-1];
    logic        pme_enable;
    logic        pme_status;

    // Loader sequencing
    assign bus.req  = (state == L_REQ);
    assign bus.addr = {2'b00, word_idx};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= L_REQ;
            word_idx <= 4'h0;
        end else begin
            unique case (state)
                L_REQ:  state <= L_BUSY;
                L_BUSY: if (bus.done) begin
                    // Ascending walk, stops after the last header word
                    state    <= (word_idx == `LAST_WORD) ? L_DONE : L_REQ;
                    word_idx <= word_idx + 4'h1;
                end
                L_DONE: state <= L_DONE;
            endcase
        end
    end

    // Reserved words 2,3,8,9 are never captured; driver area never addressed
    generate
        for (genvar i = 0; i < `LOAD_WORDS; i++) begin : g_word
            if (i == 2 || i == 3 || i == 8 || i == 9) begin : g_reserved
                assign word_q[i] = 16'h0000;
            end else begin : g_keep
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        word_q[i] <= 16'h0000;
                    end else if (state == L_BUSY && bus.done && word_idx == 4'(i)) begin
                        word_q[i] <= bus.data;
                    end
                end
            end
        end
    endgenerate

    // Field extraction
    wire        loaded     = (state == L_DONE);
    wire [7:0]  autoload   = word_q[`W_AUTOLOAD][7:0];
    wire [7:0]  new_cap    = word_q[`W_AUTOLOAD][15:8];
    wire [7:0]  power_cap  = word_q[`W_POWER][7:0];
    wire [7:0]  power_ctl  = word_q[`W_POWER][15:8];
    wire        vid_en     = loaded && (autoload[3:0] == `VID_AUTOLOAD_KEY);
    wire        cap_en     = loaded && autoload[`BIT_CAP_A] && autoload[`BIT_CAP_B];
    wire [7:0]  nce_eff    = cap_en ? new_cap : 8'h00;
    wire [7:0]  pmc_eff    = cap_en ? power_cap : 8'h00;
    wire [3:0]  pctl_eff   = cap_en ? power_ctl[3:0] : 4'h0;
    wire [7:0]  nce_map    = nce_eff[1] ? nce_eff : 8'h00;
    wire        active_low = loaded && autoload[`BIT_WAKE_POL];
    wire        level_mode = loaded && autoload[`BIT_WAKE_LEVEL];

    // Shadow of configuration space words
    wire [31:0] id_val     = vid_en ? {word_q[`W_DEVICE], word_q[`W_VENDOR]}
                                    : {DEFAULT_DEVICE_ID, DEFAULT_VENDOR_ID};
    wire [31:0] cmd_val    = {11'h000, nce_eff[0], 20'h00000};
    wire [31:0] subsys_val = {word_q[`W_SUB_ID], word_q[`W_SUB_VENDOR]};
    wire [31:0] pmcap_val  = {pmc_eff[7:3],
                              pmc_eff[1:0], nce_map[7:5], pmc_eff[2],
                              2'b00, nce_map[4:2], 16'h0000};
    wire [31:0] pmctl_val  = {16'h0000, pme_status, 6'h00, pme_enable, 4'h0, pctl_eff};
    wire [31:0] st_lo_val  = {word_q[`W_STATION1], word_q[`W_STATION0]};
    wire [31:0] st_hi_val  = {16'h0000, word_q[`W_STATION2]};
    wire [31:0] status_val = {28'h0000000, cap_en, vid_en, !loaded, loaded};

    // APB decode
    wire hit_id     = (paddr == `REG_ID);
    wire hit_cmd    = (paddr == `REG_CMD_STATUS);
    wire hit_subsys = (paddr == `REG_SUBSYS);
    wire hit_pmcap  = (paddr == `REG_PM_CAP);
    wire hit_pmctl  = (paddr == `REG_PM_CTRL);
    wire hit_st_lo  = (paddr == `REG_STATION_LO);
    wire hit_st_hi  = (paddr == `REG_STATION_HI);
    wire hit_status = (paddr == `REG_LOAD_STATUS);
    wire hit_any    = hit_id | hit_cmd | hit_subsys | hit_pmcap | hit_pmctl
                    | hit_st_lo | hit_st_hi | hit_status;
    wire setup      = psel && !penable;
    wire wr_pmctl   = psel && penable && pwrite && hit_pmctl;
    wire pme_clear  = wr_pmctl && pwdata[`BIT_PME_STATUS];
    wire [31:0] rd_val = ({32{hit_id}}     & id_val)
                       | ({32{hit_cmd}}    & cmd_val)
                       | ({32{hit_subsys}} & subsys_val)
                       | ({32{hit_pmcap}}  & pmcap_val)
                       | ({32{hit_pmctl}}  & pmctl_val)
                       | ({32{hit_st_lo}}  & st_lo_val)
                       | ({32{hit_st_hi}}  & st_hi_val)
                       | ({32{hit_status}} & status_val);

    // Answer staged in setup so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h00000000;
            pslverr    <= 1'b0;
            pready     <= 1'b0;
            pme_enable <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= (pwrite || !hit_any) ? 32'h00000000 : rd_val;
                pslverr <= !hit_any;
            end
            if (wr_pmctl) begin
                pme_enable <= pwdata[`BIT_PME_EN];
            end
        end
    end

    eeprom_word_reader #(
        .SK_HALF (SK_HALF)
    ) u_reader (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (bus),
        .ee_cs   (ee_cs),
        .ee_sk   (ee_sk),
        .ee_di   (ee_di),
        .ee_do   (ee_do)
    );

    wake_pin_driver #(
        .PULSE_CYC (PULSE_CYC)
    ) u_wake (
        .pclk               (pclk),
        .presetn            (presetn),
        .link_change_event  (link_change_event),
        .magic_packet_event (magic_packet_event),
        .power_ctrl         (pctl_eff),
        .active_low         (active_low),
        .level_mode         (level_mode),
        .pme_enable         (pme_enable),
        .pme_clear          (pme_clear),
        .pme_status         (pme_status),
        .wake_pin           (wake_pin),
        .pme_n_out          (pme_n_out),
        .pme_n_oe           (pme_n_oe)
    );

    a_load_count: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(loaded) |-> word_idx == 4'hD)
        else $error("load ended after wrong number of words");
    a_walk_order: assert property (@(posedge pclk) disable iff (!presetn)
        state == L_BUSY && bus.done |=> word_idx == $past(word_idx) + 4'h1)
        else $error("word walk not ascending");
    a_subsys_copy: assert property (@(posedge pclk) disable iff (!presetn)
        loaded |-> subsys_val == {word_q[1], word_q[0]})
        else $error("subsystem word mismatch");
    a_vid_gate: assert property (@(posedge pclk) disable iff (!presetn)
        autoload[3:0] != 4'hA |-> id_val == {DEFAULT_DEVICE_ID, DEFAULT_VENDOR_ID})
        else $error("default IDs not shown");
    a_vid_load: assert property (@(posedge pclk) disable iff (!presetn)
        loaded && autoload[3:0] == 4'hA |-> id_val == {word_q[6], word_q[5]})
        else $error("vendor/device not loaded");
    a_cap_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !(autoload[7] && autoload[5]) |-> pmcap_val == 32'h0 && cmd_val == 32'h0)
        else $error("capability bytes leaked");
    a_pmc_map: assert property (@(posedge pclk) disable iff (!presetn)
        cap_en |-> pmcap_val[31:27] == power_cap[7:3] && pmcap_val[21] == power_cap[2]
               && pmcap_val[26:25] == power_cap[1:0] && cmd_val[20] == new_cap[0])
        else $error("power capability mapping wrong");
    a_station_order: assert property (@(posedge pclk) disable iff (!presetn)
        loaded |-> st_lo_val[7:0] == word_q[10][7:0]
               && st_hi_val[15:8] == word_q[12][15:8])
        else $error("station byte order wrong");
    c_load_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(loaded));
    c_vid_loaded: cover property (@(posedge pclk) disable iff (!presetn) vid_en);
    c_cap_loaded: cover property (@(posedge pclk) disable iff (!presetn) cap_en && nce_eff[1]);
    c_pme_driven: cover property (@(posedge pclk) disable iff (!presetn) pme_n_oe);
endmodule
`default_nettype wire

// [serial_eeprom_params.svh]
`ifndef SERIAL_EEPROM_PARAMS_SVH
`define SERIAL_EEPROM_PARAMS_SVH

`define CLK_PERIOD_NS    10
`define EE_SK_HALF_NS    400
`define EE_SK_HALF_CYC   (`EE_SK_HALF_NS / `CLK_PERIOD_NS)
`define WAKE_PULSE_NS    1000
`define WAKE_PULSE_CYC   (`WAKE_PULSE_NS / `CLK_PERIOD_NS)

`define LOAD_WORDS       13
`define LAST_WORD        4'hC
`define EE_READ_OP       2'b10
`define EE_LAST_CMD_CLK  5'h08
`define EE_LAST_CLK      5'h18

`define W_SUB_VENDOR     0
`define W_SUB_ID         1
`define W_AUTOLOAD       4
`define W_VENDOR         5
`define W_DEVICE         6
`define W_POWER          7
`define W_STATION0       10
`define W_STATION1       11
`define W_STATION2       12

`define VID_AUTOLOAD_KEY 4'hA
`define BIT_CAP_A        7
`define BIT_CAP_B        5
`define BIT_WAKE_POL     4
`define BIT_WAKE_LEVEL   6
`define BIT_NEW_CAP      20
`define BIT_PME_EN       8
`define BIT_PME_STATUS   15

`define REG_ID           12'h000
`define REG_CMD_STATUS   12'h004
`define REG_SUBSYS       12'h02C
`define REG_PM_CAP       12'h050
`define REG_PM_CTRL      12'h054
`define REG_STATION_LO   12'h060
`define REG_STATION_HI   12'h064
`define REG_LOAD_STATUS  12'h068

`endif

// [serial_eeprom_pkg.sv]
package serial_eeprom_pkg;
    typedef enum logic [2:0] {
        L_REQ  = 3'b001,
        L_BUSY = 3'b010,
        L_DONE = 3'b100
    } load_state_type;
    typedef enum logic [2:0] {
        R_IDLE  = 3'b001,
        R_SHIFT = 3'b010,
        R_GAP   = 3'b100
    } read_state_type;
    typedef logic [15:0] word_type;
endpackage

// [eeprom_bus_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface eeprom_bus_if;
    logic       req;
    logic [5:0] addr;
    logic [15:0] data;
    logic       done;
    modport loader (output req, output addr, input data, input done);
    modport reader (input req, input addr, output data, output done);
endinterface
`default_nettype wire

// [eeprom_word_reader.sv]
`timescale 1ns/1ns
`default_nettype none
`include "serial_eeprom_params.svh"
module eeprom_word_reader #(
    parameter int SK_HALF = `EE_SK_HALF_CYC
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    eeprom_bus_if.reader bus,
    output var logic   ee_cs,
    output var logic   ee_sk,
    output var logic   ee_di,
    input  wire logic  ee_do
);
    import serial_eeprom_pkg::*;
    read_state_type state;
    logic [7:0]  div_cnt;
    logic [4:0]  clk_no;
    logic [8:0]  cmd_sr;
    logic [15:0] data_sr;
    logic        do_meta;
    logic        do_sync;
    wire  half_end = (div_cnt == 8'(SK_HALF - 1));
    wire  sk_fall  = (state == R_SHIFT) && half_end && ee_sk;
    wire  frame_end = sk_fall && (clk_no == `EE_LAST_CLK);
    // Data follows the dummy zero; sampled late in the clock to absorb the synchroniser
    wire  sample   = sk_fall && (clk_no > `EE_LAST_CMD_CLK);
    wire [15:0] next_data_sr = sample ? {data_sr[14:0], do_sync} : data_sr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            do_meta <= 1'b0;
            do_sync <= 1'b0;
        end else begin
            do_meta <= ee_do;
            do_sync <= do_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= R_IDLE;
            div_cnt  <= 8'h00;
            clk_no   <= 5'h00;
            cmd_sr   <= 9'h000;
            data_sr  <= 16'h0000;
            ee_cs    <= 1'b0;
            ee_sk    <= 1'b0;
            ee_di    <= 1'b0;
            bus.done <= 1'b0;
            bus.data <= 16'h0000;
        end else begin
            // Done only after the gap, so the next request finds the reader idle
            bus.done <= (state == R_GAP) && half_end;
            data_sr  <= next_data_sr;
            div_cnt  <= (state == R_IDLE || half_end) ? 8'h00 : div_cnt + 8'h01;
            unique case (state)
                R_IDLE: if (bus.req) begin
                    state  <= R_SHIFT;
                    ee_cs  <= 1'b1;
                    ee_di  <= 1'b1;
                    cmd_sr <= {1'b1, `EE_READ_OP, bus.addr};
                    clk_no <= 5'h00;
                end
                R_SHIFT: if (half_end) begin
                    ee_sk <= ~ee_sk;
                    if (ee_sk) begin
                        clk_no <= clk_no + 5'h01;
                        ee_di  <= cmd_sr[7];
                        cmd_sr <= {cmd_sr[7:0], 1'b0};
                    end
                    if (frame_end) begin
                        state    <= R_GAP;
                        ee_cs    <= 1'b0;
                        bus.data <= next_data_sr;
                    end
                end
                R_GAP: if (half_end) begin
                    state <= R_IDLE;
                end
            endcase
        end
    end

    a_clock_framed: assert property (@(posedge pclk) disable iff (!presetn)
        ee_sk |-> ee_cs)
        else $error("serial clock high outside a frame");
endmodule
`default_nettype wire

// [wake_pin_driver.sv]
`timescale 1ns/1ns
`default_nettype none
`include "serial_eeprom_params.svh"
module wake_pin_driver #(
    parameter int PULSE_CYC = `WAKE_PULSE_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic link_change_event,
    input  wire logic magic_packet_event,
    input  wire logic [3:0] power_ctrl,
    input  wire logic active_low,
    input  wire logic level_mode,
    input  wire logic pme_enable,
    input  wire logic pme_clear,
    output var logic  pme_status,
    output var logic  wake_pin,
    output var logic  pme_n_out,
    output var logic  pme_n_oe
);
    logic [7:0] pulse_cnt;
    wire  event_hit = (link_change_event && power_ctrl[1])
                   || (magic_packet_event && power_ctrl[0]);
    wire  pulse_on  = (pulse_cnt != 8'h00);
    wire  asserted  = level_mode ? pme_status : pulse_on;
    wire  next_wake = power_ctrl[2] ? active_low
                                    : (asserted ^ active_low);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pme_status <= 1'b0;
            pulse_cnt  <= 8'h00;
            wake_pin   <= 1'b0;
            pme_n_out  <= 1'b0;
            pme_n_oe   <= 1'b0;
        end else begin
            // Set wins over a simultaneous software clear
            pme_status <= event_hit || (pme_status && !pme_clear);
            pulse_cnt  <= event_hit ? 8'(PULSE_CYC) : (pulse_on ? pulse_cnt - 8'h01 : 8'h00);
            wake_pin   <= next_wake;
            pme_n_oe   <= pme_status && pme_enable && !power_ctrl[3];
        end
    end

    a_pme_never: assert property (@(posedge pclk) disable iff (!presetn)
        power_ctrl[3] && $past(power_ctrl[3]) |-> !pme_n_oe)
        else $error("PME driven while disabled");
    a_wake_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        power_ctrl[2] && $stable(active_low) |=> wake_pin == active_low)
        else $error("wake pin active while disabled");
    a_wake_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        event_hit && !level_mode && !power_ctrl[2] && $stable(active_low)
        |=> ##1 wake_pin != active_low)
        else $error("wake pulse missing");
    c_wake_pulse: cover property (@(posedge pclk) disable iff (!presetn)
        event_hit && !level_mode ##2 wake_pin != active_low);
endmodule
`default_nettype wire

// [eeprom_model.sv]
`timescale 1ns/1ns
`default_nettype none
module eeprom_model (
    input  wire logic ee_cs,
    input  wire logic ee_sk,
    input  wire logic ee_di,
    output var logic  ee_do
);
    logic [15:0] mem [0:63]; // 128 bytes, rest is driver area
    logic [5:0]  seen [$];
    logic [8:0]  cmd;
    int          n;
    initial begin
        ee_do = 1'b0;
        cmd   = 9'h000;
        n     = 0;
    end
    // Deselected line must not hold its last value
    always @(negedge ee_cs) begin
        n     = 0;
        ee_do = (ee_do === 1'b1) ? 1'b0 : 1'b1;
    end
    always @(posedge ee_sk) begin
        if (ee_cs === 1'b1) begin
            n = n + 1;
            if (n <= 9)
                cmd = {cmd[7:0], ee_di};
            if (n == 9) begin
                seen.push_back(cmd[5:0]);
                ee_do = 1'b0;
            end
            if (n >= 10 && n <= 25)
                ee_do = mem[cmd[5:0]][25 - n]; // D15 first, low byte last
        end
    end
endmodule
`default_nettype wire

// [serial_eeprom_autoload_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_autoload_bench;
    import serial_eeprom_pkg::*;
    localparam logic [15:0] DEF_VID = 16'h1234; // Arbitrary value
    localparam logic [15:0] DEF_DID = 16'h8765; // Arbitrary value
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ee_cs;
    logic        ee_sk;
    logic        ee_di;
    logic        ee_do;
    logic        link_change_event;
    logic        magic_packet_event;
    logic        wake_pin;
    logic        pme_n_out;
    logic        pme_n_oe;
    int          fails;
    int          check_count;
    int          cycles;
    serial_eeprom_autoload #(.DEFAULT_VENDOR_ID(DEF_VID), .DEFAULT_DEVICE_ID(DEF_DID),
        .SK_HALF(4), .PULSE_CYC(4)) uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do),
        .link_change_event(link_change_event), .magic_packet_event(magic_packet_event),
        .wake_pin(wake_pin), .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe));
    eeprom_model eeprom (.ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Generous ceiling: four loads of about 3000 cycles each
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(nm, exp, r & m);
    endtask
    task automatic pulse(input logic magic);
        @(posedge pclk);
        if (magic)
            magic_packet_event <= 1'b1;
        else
            link_change_event <= 1'b1;
        @(posedge pclk);
        magic_packet_event <= 1'b0;
        link_change_event  <= 1'b0;
    endtask
    // Counts cycles of wake pin high and of PME drive over 24 cycles
    task automatic watch(input int s, input int w_exp, input int p_exp, input string nm);
        int w;
        int p;
        w = 0;
        p = 0;
        repeat (s) @(posedge pclk);
        repeat (24) begin
            @(posedge pclk);
            w += (wake_pin === 1'b1) ? 1 : 0;
            p += (pme_n_oe === 1'b1) ? 1 : 0;
        end
        chk({nm, " wake"}, w_exp, w);
        chk({nm, " pme"}, p_exp, p);
    endtask
    function automatic logic [31:0] exp_cap(input logic [7:0] new_capability_byte, input logic [7:0] power_capability_byte);
        logic [7:0] n;
        n = new_capability_byte[1] ? new_capability_byte : 8'h00;
        return {power_capability_byte[7:3], power_capability_byte[1:0], n[7:5], power_capability_byte[2], 2'b00, n[4:2], 16'h0000};
    endfunction
    task automatic run_load(input logic [7:0] k, input logic [7:0] auto, input logic [7:0] new_capability_byte,
                            input logic [7:0] power_capability_byte, input logic [7:0] pwr);
        word_type    m [0:12];
        logic [31:0] r;
        logic        e;
        logic        vid_on;
        logic        cap_on;
        int          i;
        for (i = 0; i < 64; i++)
            eeprom.mem[i] = {k, 8'(i)};
        eeprom.mem[4] = {new_capability_byte, auto}; // Lower byte offset is the low byte
        eeprom.mem[7] = {pwr, power_capability_byte};
        for (i = 0; i < 13; i++)
            m[i] = eeprom.mem[i];
        vid_on = (auto[3:0] == 4'hA);
        cap_on = auto[7] & auto[5];
        presetn <= 1'b0;
        eeprom.seen.delete();
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 2000; i++) begin
            apb(1'b0, 12'h068, 32'h0000_0000, r, e);
            if (r[0] === 1'b1)
                break;
        end
        chk("load status", {28'h0, cap_on, vid_on, 2'b01}, r & 32'h0000_000F);
        chk("word count", 32'd13, eeprom.seen.size());
        for (i = 0; i < eeprom.seen.size(); i++)
            chk("word order", i, eeprom.seen[i]);
        rd_chk("ids", 12'h000, 32'hFFFF_FFFF,
               vid_on ? {m[6], m[5]} : {DEF_DID, DEF_VID});
        rd_chk("subsystem", 12'h02C, 32'hFFFF_FFFF, {m[1], m[0]});
        rd_chk("new cap flag", 12'h004, 32'h0010_0000, {11'h0, cap_on & new_capability_byte[0], 20'h0});
        rd_chk("pm cap", 12'h050, 32'hFFFF_FFFF,
               cap_on ? exp_cap(new_capability_byte, power_capability_byte) : 32'h0);
        rd_chk("pm ctrl", 12'h054, 32'h0000_000F, {28'h0, cap_on ? pwr[3:0] : 4'h0});
        rd_chk("station lo", 12'h060, 32'hFFFF_FFFF, {m[11], m[10]});
        rd_chk("station hi", 12'h064, 32'hFFFF_FFFF, {16'h0, m[12]});
        chk("pme level", 32'h0, pme_n_out);
    endtask
    task automatic test_level_low();
        logic [31:0] r;
        logic        e;
        run_load(8'h31, 8'hFA, 8'hB7, 8'h5E, 8'h03);
        apb(1'b0, 12'h0F0, 32'h0000_0000, r, e);
        chk("unmapped err", 32'h1, e);
        chk("unmapped data", 32'h0, r);
        wr(12'h000, 32'hFFFF_FFFF);
        rd_chk("read only ids", 12'h000, 32'hFFFF_FFFF, {eeprom.mem[6], eeprom.mem[5]});
        watch(4, 24, 0, "idle");
        pulse(1'b1);
        watch(4, 0, 0, "magic level");
        wr(12'h054, 32'h0000_0100);
        watch(4, 0, 24, "pme on");
        wr(12'h054, 32'h0000_8100);
        watch(4, 24, 0, "cleared");
        pulse(1'b0);
        watch(4, 0, 24, "link level");
        $display("test level_low done");
    endtask
    task automatic test_pulse_high();
        run_load(8'h52, 8'hA5, 8'h6C, 8'hA3, 8'h01);
        pulse(1'b0);
        watch(0, 0, 0, "link off");
        pulse(1'b1);
        watch(0, 4, 0, "magic pulse");
        $display("test pulse_high done");
    endtask
    task automatic test_no_cap();
        run_load(8'h73, 8'h0A, 8'hFF, 8'hFF, 8'h03);
        pulse(1'b1);
        watch(0, 0, 0, "unloaded");
        $display("test no_cap done");
    endtask
    task automatic test_disabled();
        run_load(8'h94, 8'hFA, 8'h01, 8'h07, 8'h0F);
        pulse(1'b1);
        watch(4, 24, 0, "wake off");
        wr(12'h054, 32'h0000_0100);
        watch(4, 24, 0, "pme off");
        $display("test disabled done");
    endtask
    initial begin
        presetn            = 1'b0;
        paddr              = 12'h000;
        psel               = 1'b0;
        penable            = 1'b0;
        pwrite             = 1'b0;
        pwdata             = 32'h0000_0000;
        link_change_event  = 1'b0;
        magic_packet_event = 1'b0;
        fails              = 0;
        check_count        = 0;
        cycles             = 0;
        test_level_low();
        test_pulse_high();
        test_no_cap();
        test_disabled();
        tally_and_finish();
    end
endmodule
`default_nettype wire
